// file: include/rpc_pkg.sv
// constants, types and register map of the reset and power control block
// Function
// - brownout resets the core by default; a control bit makes it interrupt
// - software enable gates brownout; disabled means neither reset nor interrupt
// - brownout condition follows supply-low indication while detection is enabled
// - power-up sets power-on flag, kept until software clears it
// - idle keeps peripherals running; enabled interrupt or reset ends idle
// - power-down stops main oscillator; reset or wake interrupt ends it
// - brownout, watchdog, comparators and rtc stay alive in power-down
// - rc oscillator gated in power-down unless it is sysclk with rtc on
// - total power-down also disables brownout detector and comparators
// - pin enable bit set: pin is active-low reset, else plain input
// - during power-up the pin is always reset; low pin holds reset
// - only power-up overrides pin enable; other resets keep pin function
// - reset from pin, power-on, brownout, watchdog, software, uart break
// - each reset source owns a readable flag bit
// - writing 0 clears a flag; several flags may be set together
// - power-on reset sets power-on and brownout flags, clears the rest
// - other resets set own flag and keep uncleared flags
// - enabled external interrupt wakes from idle and power-down
package rpc_pkg;
  // ==========================================================
  // bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_USER_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESET_SOURCE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  // ==========================================================
  // field positions and reset values
  localparam int UCFG_W = 2;
  localparam int UCFG_BO_FUSE = 0;
  localparam int UCFG_RPE = 1;
  localparam logic [UCFG_W-1:0] UCFG_RST = 2'h1;
  localparam int CTRL_W = 5;
  localparam int CTL_BOD_EN = 0;
  localparam int CTL_BO_IRQ = 1;
  localparam int CTL_RC_SYS = 2;
  localparam int CTL_RTC_EN = 3;
  localparam int CTL_CMP_OFF = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h01;
  localparam int FLAGS_W = 6;
  localparam int FLG_PIN = 0;
  localparam int FLG_SW = 1;
  localparam int FLG_WDT = 2;
  localparam int FLG_BRK = 3;
  localparam int FLG_BO = 4;
  localparam int FLG_POR = 5;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 6'h30;
  localparam int ST_BO = 0;
  localparam int ST_PIN = 1;
  localparam int ST_PU = 2;
  localparam int ST_MODE = 4;
  // mode codes as software writes and reads them
  localparam logic [1:0] MCODE_RUN = 2'h0;
  localparam logic [1:0] MCODE_IDLE = 2'h1;
  localparam logic [1:0] MCODE_PD = 2'h2;
  localparam logic [1:0] MCODE_TPD = 2'h3;
  // ==========================================================
  // power-up window
  localparam int CLK_PERIOD_NS = 8;
  localparam int POWERUP_TIME_NS = 512;
  localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PU_CNT_W = 7;
  localparam logic [PU_CNT_W-1:0] PU_LAST = PU_CNT_W'(POWERUP_CYCLES - 1);
  // ==========================================================
  // types
  typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PD, MODE_TPD} mode_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } reg_wr_t;
endpackage

// file: logic/reset_release.sv
// reset synchroniser: asynchronous assertion, two-stage clocked release
module reset_release
  import rpc_pkg::*;
(
  // clock and combined reset request
  input wire logic i_clk,
  input wire logic i_arst_b,
  // released reset
  output logic o_rst_b
);
  logic stage1;

  // stage1 feeds only the second stage
  always_ff @(posedge i_clk or negedge i_arst_b)
  begin
    if (!i_arst_b)
    begin
      stage1 <= 1'b0;
      o_rst_b <= 1'b0;
    end
    else
    begin
      stage1 <= 1'b1;
      o_rst_b <= stage1;
    end
  end
endmodule

// file: logic/axil_regport.sv
// axi4-lite slave that turns bus transfers into register strobes
module axil_regport
  import rpc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [STRB_W-1:0] i_wstrb,
  // write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // register side
  output logic o_wr_en,
  output reg_wr_t o_wr,
  input wire logic i_wr_ok,
  output logic [ADDR_W-1:0] o_rd_addr,
  input wire logic [DATA_W-1:0] i_rd_data,
  input wire logic i_rd_ok
);
  logic wr_take;
  logic rd_take;

  // address and data taken together, one write in flight
  assign wr_take = i_awvalid & i_wvalid & ~o_bvalid;
  assign o_awready = wr_take;
  assign o_wready = wr_take;
  assign o_wr_en = wr_take;
  assign o_wr = '{addr: i_awaddr, data: i_wdata, strb: i_wstrb};
  assign rd_take = i_arvalid & ~o_rvalid;
  assign o_arready = rd_take;
  assign o_rd_addr = i_araddr;

  // write response, held until bready
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else if (wr_take)
    begin
      o_bvalid <= 1'b1;
      o_bresp <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // read data, held until rready
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      o_rvalid <= 1'b1;
      o_rdata <= i_rd_data;
      o_rresp <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end
endmodule

// file: logic/reset_power_control.sv
// reset sources, power modes and reset-source flags behind an axi4-lite port
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
module reset_power_control
  import rpc_pkg::*;
(
  // clock and power-on reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // axi4-lite write address and data
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic [STRB_W-1:0] I_WSTRB,
  // axi4-lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // axi4-lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [DATA_W-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // supply monitor and reset sources
  input wire logic I_SUPPLY_LOW,
  input wire logic I_SHARED_RESET_INPUT_PIN,
  input wire logic I_WDT_RESET,
  input wire logic I_SW_RESET,
  input wire logic I_UART_BREAK,
  // interrupt requests that may wake the core
  input wire logic I_IRQ_PENDING,
  input wire logic I_EXT_IRQ,
  input wire logic I_WAKE_IRQ,
  // reset, interrupt, wake and pin data outputs
  output logic O_RESET_B,
  output logic O_BROWNOUT_IRQ,
  output logic O_WAKE,
  output logic O_PIN_DATA,
  // clock and analog block gating
  output logic O_CPU_CLK_EN,
  output logic O_PERIPH_CLK_EN,
  output logic O_MAIN_OSC_EN,
  output logic O_RC_OSC_EN,
  output logic O_BOD_EN,
  output logic O_CMP_EN,
  output logic O_WDT_EN,
  output logic O_RTC_EN
);
  // ==========================================================
  // declarations
  logic [UCFG_W-1:0] ucfg;
  logic [CTRL_W-1:0] ctrl;
  logic [FLAGS_W-1:0] flags;
  logic [FLAGS_W-1:0] flag_set;
  logic [FLAGS_W-1:0] flag_clr;
  mode_t mode;
  mode_t next_mode;
  logic powerup;
  logic [PU_CNT_W-1:0] pu_cnt;
  logic wr_en;
  reg_wr_t wr;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  logic flag_wr;
  logic bo_en_eff;
  logic bo_cond;
  logic bo_rst;
  logic pin_is_rst;
  logic pin_rst;
  logic any_src;
  logic arst_b;
  logic low_power;

  // ==========================================================
  // helpers
  // word-aligned register match
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // any mapped register
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = reg_hit(a, OFF_USER_CONFIG) | reg_hit(a, OFF_CONTROL) |
                 reg_hit(a, OFF_MODE) | reg_hit(a, OFF_RESET_SOURCE) |
                 reg_hit(a, OFF_STATUS);
  endfunction

  // mode to software code
  function automatic logic [1:0] mode_code(input mode_t m);
    case (m)
      MODE_IDLE: mode_code = MCODE_IDLE;
      MODE_PD: mode_code = MCODE_PD;
      MODE_TPD: mode_code = MCODE_TPD;
      default: mode_code = MCODE_RUN;
    endcase
  endfunction

  // software code to mode
  function automatic mode_t code_mode(input logic [1:0] c);
    case (c)
      MCODE_IDLE: code_mode = MODE_IDLE;
      MCODE_PD: code_mode = MODE_PD;
      MCODE_TPD: code_mode = MODE_TPD;
      default: code_mode = MODE_RUN;
    endcase
  endfunction

  // ==========================================================
  // register port
  axil_regport u_regport (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_awaddr(I_AWADDR),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .o_bresp(O_BRESP),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .i_araddr(I_ARADDR),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_wr_en(wr_en),
    .o_wr(wr),
    .i_wr_ok(wr_ok),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok)
  );

  assign wr_ok = reg_mapped(wr.addr);

  // read mux, unmapped answers slverr with zero data
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (reg_hit(rd_addr, OFF_USER_CONFIG))
      rd_data[UCFG_W-1:0] = ucfg;
    else if (reg_hit(rd_addr, OFF_CONTROL))
      rd_data[CTRL_W-1:0] = ctrl;
    else if (reg_hit(rd_addr, OFF_MODE))
      rd_data[1:0] = mode_code(mode);
    else if (reg_hit(rd_addr, OFF_RESET_SOURCE))
      rd_data[FLAGS_W-1:0] = flags;
    else if (reg_hit(rd_addr, OFF_STATUS))
    begin
      rd_data[ST_BO] = bo_cond;
      rd_data[ST_PIN] = I_SHARED_RESET_INPUT_PIN;
      rd_data[ST_PU] = powerup;
      rd_data[ST_MODE+:2] = mode_code(mode);
    end
    else
      rd_ok = 1'b0;
  end

  // configuration and control registers
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      ucfg <= UCFG_RST;
      ctrl <= CTRL_RST;
    end
    else if (wr_en && wr.strb[0])
    begin
      if (reg_hit(wr.addr, OFF_USER_CONFIG))
        ucfg <= wr.data[UCFG_W-1:0];
      if (reg_hit(wr.addr, OFF_CONTROL))
        ctrl <= wr.data[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // brownout and pin reset
  assign low_power = (mode == MODE_PD) | (mode == MODE_TPD);
  assign bo_en_eff = ctrl[CTL_BOD_EN] & (mode != MODE_TPD);
  assign bo_cond = bo_en_eff & I_SUPPLY_LOW;
  assign bo_rst = bo_cond & ~ctrl[CTL_BO_IRQ] & ucfg[UCFG_BO_FUSE];
  assign pin_is_rst = powerup | ucfg[UCFG_RPE];
  assign pin_rst = pin_is_rst & ~I_SHARED_RESET_INPUT_PIN;
  assign any_src = pin_rst | bo_rst | I_WDT_RESET | I_SW_RESET | I_UART_BREAK;
  assign arst_b = I_RST_B & ~any_src & ~powerup;

  // power-up window restarts while the pin is held low
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      powerup <= 1'b1;
      pu_cnt <= '0;
    end
    else if (powerup)
    begin
      if (!I_SHARED_RESET_INPUT_PIN)
        pu_cnt <= '0;
      else if (pu_cnt == PU_LAST)
        powerup <= 1'b0;
      else
        pu_cnt <= pu_cnt + 1'b1;
    end
  end

  // internal reset release
  reset_release u_release (
    .i_clk(I_CLOCK),
    .i_arst_b(arst_b),
    .o_rst_b(O_RESET_B)
  );

  // brownout interrupt and plain pin input
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_BROWNOUT_IRQ <= 1'b0;
      O_PIN_DATA <= 1'b1;
    end
    else
    begin
      O_BROWNOUT_IRQ <= bo_cond & ctrl[CTL_BO_IRQ];
      O_PIN_DATA <= pin_is_rst | I_SHARED_RESET_INPUT_PIN;
    end
  end

  // ==========================================================
  // reset-source flags, set wins over a software clear
  assign flag_wr = wr_en & wr.strb[0] & reg_hit(wr.addr, OFF_RESET_SOURCE);
  assign flag_clr = flag_wr ? ~wr.data[FLAGS_W-1:0] : '0;
  always_comb
  begin
    flag_set = '0;
    flag_set[FLG_PIN] = pin_rst & ~powerup;
    flag_set[FLG_SW] = I_SW_RESET;
    flag_set[FLG_WDT] = I_WDT_RESET;
    flag_set[FLG_BRK] = I_UART_BREAK;
    flag_set[FLG_BO] = bo_rst;
  end

  // power-on reset loads power-on and brownout flags only
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      flags <= FLAGS_RST;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end

  // ==========================================================
  // power mode state
  always_comb
  begin
    next_mode = mode;
    if (any_src || powerup)
      next_mode = MODE_RUN;
    else
      case (mode)
        MODE_RUN:
          if (wr_en && wr.strb[0] && reg_hit(wr.addr, OFF_MODE))
            next_mode = code_mode(wr.data[1:0]);
        MODE_IDLE:
          if (I_IRQ_PENDING || I_EXT_IRQ)
            next_mode = MODE_RUN;
        MODE_PD, MODE_TPD:
          if (I_WAKE_IRQ || I_EXT_IRQ)
            next_mode = MODE_RUN;
        default:
          next_mode = MODE_RUN;
      endcase
  end

  // mode register and wake pulse
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      mode <= MODE_RUN;
      O_WAKE <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      O_WAKE <= (mode != MODE_RUN) && (next_mode == MODE_RUN);
    end
  end

  // clock and analog gating follows the mode and control bits; watchdog enable stays on
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_CPU_CLK_EN <= 1'b1;
      O_PERIPH_CLK_EN <= 1'b1;
      O_MAIN_OSC_EN <= 1'b1;
      O_RC_OSC_EN <= 1'b1;
      O_BOD_EN <= 1'b1;
      O_CMP_EN <= 1'b1;
      O_WDT_EN <= 1'b1;
      O_RTC_EN <= 1'b0;
    end
    else
    begin
      O_CPU_CLK_EN <= (mode == MODE_RUN);
      O_PERIPH_CLK_EN <= ~low_power;
      O_MAIN_OSC_EN <= ~low_power;
      O_RC_OSC_EN <= ~low_power | (ctrl[CTL_RC_SYS] & ctrl[CTL_RTC_EN]);
      O_BOD_EN <= bo_en_eff;
      O_CMP_EN <= ~ctrl[CTL_CMP_OFF] & (mode != MODE_TPD);
      O_WDT_EN <= 1'b1;
      O_RTC_EN <= ctrl[CTL_RTC_EN];
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);

  property p_bo_reset;
    (bo_cond && !ctrl[CTL_BO_IRQ] && ucfg[UCFG_BO_FUSE]) |-> !O_RESET_B;
  endproperty
  a_bo_reset: assert property (p_bo_reset) else $error("brownout did not reset");

  property p_bo_irq;
    (bo_cond && ctrl[CTL_BO_IRQ]) |=> O_BROWNOUT_IRQ;
  endproperty
  a_bo_irq: assert property (p_bo_irq) else $error("brownout irq missing");

  property p_bo_off;
    (!ctrl[CTL_BOD_EN] || mode == MODE_TPD) |=> !O_BROWNOUT_IRQ;
  endproperty
  a_bo_off: assert property (p_bo_off) else $error("irq while detector off");

  property p_bo_negate;
    (ctrl[CTL_BO_IRQ] && !I_SUPPLY_LOW) |=> !O_BROWNOUT_IRQ;
  endproperty
  a_bo_negate: assert property (p_bo_negate) else $error("brownout not negated");

  property p_pof_sticky;
    (flags[FLG_POR] && !(flag_wr && !wr.data[FLG_POR])) |=> flags[FLG_POR];
  endproperty
  a_pof_sticky: assert property (p_pof_sticky) else $error("power-on flag lost");

  property p_idle_exit;
    (mode == MODE_IDLE && I_IRQ_PENDING) |=> (mode == MODE_RUN) && O_WAKE;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not ended");

  property p_pd_exit;
    (low_power && (I_WAKE_IRQ || I_EXT_IRQ)) |=> (mode == MODE_RUN) && O_WAKE;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not ended");

  property p_pd_osc;
    low_power |=> !O_MAIN_OSC_EN && !O_CPU_CLK_EN;
  endproperty
  a_pd_osc: assert property (p_pd_osc) else $error("oscillator runs in power-down");

  property p_rc_gate;
    (low_power && !(ctrl[CTL_RC_SYS] && ctrl[CTL_RTC_EN])) |=> !O_RC_OSC_EN;
  endproperty
  a_rc_gate: assert property (p_rc_gate) else $error("rc oscillator not gated");

  property p_tpd_off;
    (mode == MODE_TPD) |=> !O_BOD_EN && !O_CMP_EN;
  endproperty
  a_tpd_off: assert property (p_tpd_off) else $error("detector on in total power-down");

  property p_pin_reset;
    (ucfg[UCFG_RPE] && !I_SHARED_RESET_INPUT_PIN) |-> !O_RESET_B;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");

  property p_pin_input;
    (!ucfg[UCFG_RPE] && !powerup) |=> O_PIN_DATA == $past(I_SHARED_RESET_INPUT_PIN);
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin input not passed");

  property p_pu_hold;
    (powerup && !I_SHARED_RESET_INPUT_PIN) |=> powerup && !O_RESET_B;
  endproperty
  a_pu_hold: assert property (p_pu_hold) else $error("power-up ended with pin low");

  property p_flag_keep;
    (I_WDT_RESET && !flag_wr) |=> flags[FLG_WDT] && ((flags & $past(flags)) == $past(flags));
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flags not kept");

  property p_flag_clr;
    (flag_wr && wr.data[FLAGS_W-1:0] == '0 && flag_set == '0) |=> flags == '0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear failed");

  property p_release;
    $rose(O_RESET_B) |-> $past(arst_b) && !any_src;
  endproperty
  a_release: assert property (p_release) else $error("reset released early");

  // main scenarios
  c_idle_wake: cover property (mode == MODE_IDLE ##1 mode == MODE_RUN);
  c_pd_wake: cover property (mode == MODE_PD ##1 O_WAKE);
  c_tpd: cover property (mode == MODE_TPD ##1 !O_BOD_EN);
  c_bo_irq: cover property (!O_BROWNOUT_IRQ ##1 O_BROWNOUT_IRQ);
endmodule

// file: verification/supply_reset_model.sv
// behavioural supply monitor and external reset circuit on the far side
module supply_reset_model
(
  // clock and commands from the bench
  input wire logic i_clk,
  input wire logic i_dip,
  input wire logic i_hold,
  // monitor and pin levels seen by the block
  output logic o_supply_low,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // monitor and pin
  // supply healthy and pin pulled up unless the bench commands otherwise
  initial
  begin
    o_supply_low = 1'b0;
    o_pin = 1'b1;
  end
  // levels move just after an edge, as a slow analog source would
  always @(posedge i_clk)
  begin
    o_supply_low <= i_dip;
    o_pin <= !i_hold;
  end
endmodule

// file: verification/reset_power_control_test.sv
// self-checking bench of the reset and power control block
module reset_power_control_test
  import rpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic dip, hold, wdt, sw, brk, pend, ext, wake, supply_low, pin;
  logic awready, wready, bvalid, arready, rvalid, reset_b, bo_irq, woke, pin_data;
  wire [7:0] gate;
  int mismatches, checked, n;
  // mode row: code, control, wake inputs {ext,wake,pend}, gating {rtc,cpu..wdt}
  typedef struct packed {
    logic [1:0] mcode;
    logic [4:0] ctrl;
    logic [2:0] wk;
    logic [7:0] gate;
  } mode_row_t;
  mode_row_t rows [6] = '{'{2'h1, 5'h01, 3'h1, 8'h3F}, '{2'h1, 5'h01, 3'h4, 8'h3F},
    '{2'h2, 5'h01, 3'h4, 8'h07}, '{2'h2, 5'h0D, 3'h2, 8'h8F},
    '{2'h2, 5'h11, 3'h4, 8'h05}, '{2'h3, 5'h0D, 3'h2, 8'h89}};
  // ==========================================
  // instances
  supply_reset_model far_u
  (
    .i_clk(clk), .i_dip(dip), .i_hold(hold), .o_supply_low(supply_low), .o_pin(pin)
  );
  reset_power_control dut_u
  (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_SUPPLY_LOW(supply_low),
    .I_SHARED_RESET_INPUT_PIN(pin), .I_WDT_RESET(wdt), .I_SW_RESET(sw),
    .I_UART_BREAK(brk), .I_IRQ_PENDING(pend), .I_EXT_IRQ(ext), .I_WAKE_IRQ(wake),
    .O_RESET_B(reset_b), .O_BROWNOUT_IRQ(bo_irq), .O_WAKE(woke), .O_PIN_DATA(pin_data),
    .O_CPU_CLK_EN(gate[6]), .O_PERIPH_CLK_EN(gate[5]), .O_MAIN_OSC_EN(gate[4]),
    .O_RC_OSC_EN(gate[3]), .O_BOD_EN(gate[2]), .O_CMP_EN(gate[1]), .O_WDT_EN(gate[0]),
    .O_RTC_EN(gate[7])
  );
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a bound used up counts as a mismatch and ends the run
  task automatic tmo();
    if (n >= 300)
    begin
      mismatches++;
      finish_test();
    end
  endtask
  // write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    n = 0;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 300);
    tmo();
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    n = 0;
    do @(posedge clk); while (bvalid !== 1'b1 && ++n < 300);
    tmo();
    rr = bresp;
    bready <= 1'b0;
  endtask
  // read: rready held until rvalid, data taken at that edge
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 300);
    tmo();
    arvalid <= 1'b0;
    n = 0;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 300);
    tmo();
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_rst();
    n = 0;
    do @(posedge clk); while (reset_b !== 1'b1 && ++n < 300);
    tmo();
  endtask
  task automatic wait_wake();
    n = 0;
    do @(posedge clk); while (woke !== 1'b1 && ++n < 300);
    tmo();
  endtask
  // ==========================================
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // main sequence
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {dip, hold, wdt, sw, brk, pend, ext, wake} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    chk(reset_b, 1'b0);
    wait_rst();
    rd_reg(OFF_RESET_SOURCE);
    chk(rd, 32'h30);
    rd_reg(OFF_USER_CONFIG);
    chk(rd, 32'(UCFG_RST));
    rd_reg(OFF_CONTROL);
    chk(rd, 32'(CTRL_RST));
    rd_reg(8'h40);
    chk(rr, RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(rr, RESP_SLVERR);
    // each source in turn: pin, software, watchdog, break, brownout
    wr(OFF_USER_CONFIG, 32'h3);
    wr(OFF_RESET_SOURCE, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      {dip, brk, wdt, sw, hold} <= 5'(1 << i);
      repeat (3) @(posedge clk);
      chk(reset_b, 1'b0);
      {dip, brk, wdt, sw, hold} <= 5'h0;
      wait_rst();
      rd_reg(OFF_RESET_SOURCE);
      chk(rd, 32'((2 << i) - 1));
    end
    wr(OFF_RESET_SOURCE, 32'h0A);
    rd_reg(OFF_RESET_SOURCE);
    chk(rd, 32'h0A);
    // brownout as interrupt, disabled, then masked in total power-down
    wr(OFF_CONTROL, 32'h03);
    dip <= 1'b1;
    repeat (4) @(posedge clk);
    chk({bo_irq, reset_b}, 2'b11);
    rd_reg(OFF_STATUS);
    chk(rd, 32'h3);
    wr(OFF_CONTROL, 32'h02);
    repeat (3) @(posedge clk);
    chk({bo_irq, reset_b}, 2'b01);
    wr(OFF_CONTROL, 32'h03);
    wr(OFF_MODE, 32'(MCODE_TPD));
    repeat (3) @(posedge clk);
    chk({bo_irq, reset_b, gate[2]}, 3'b010);
    wake <= 1'b1;
    wait_wake();
    wake <= 1'b0;
    dip <= 1'b0;
    repeat (4) @(posedge clk);
    chk(bo_irq, 1'b0);
    // table of low-power modes and their wake sources
    foreach (rows[i])
    begin
      wr(OFF_CONTROL, 32'(rows[i].ctrl));
      wr(OFF_MODE, 32'(rows[i].mcode));
      rd_reg(OFF_MODE);
      chk(rd, 32'(rows[i].mcode));
      repeat (3) @(posedge clk);
      chk(gate, rows[i].gate);
      {ext, wake, pend} <= rows[i].wk;
      wait_wake();
      {ext, wake, pend} <= 3'h0;
      repeat (2) @(posedge clk);
      chk(gate[6], 1'b1);
    end
    // brownout fuse clear: supply dip neither resets nor interrupts
    wr(OFF_USER_CONFIG, 32'h0);
    dip <= 1'b1;
    repeat (4) @(posedge clk);
    chk({bo_irq, reset_b}, 2'b01);
    dip <= 1'b0;
    // pin as plain input, kept so across a software reset
    wr(OFF_USER_CONFIG, 32'h1);
    hold <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pin_data, reset_b}, 2'b01);
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    wait_rst();
    chk(pin_data, 1'b0);
    // power-up with pin held low stays in reset
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (100) @(posedge clk);
    chk(reset_b, 1'b0);
    rd_reg(OFF_STATUS);
    chk(rd, 32'h4);
    hold <= 1'b0;
    wait_rst();
    rd_reg(OFF_RESET_SOURCE);
    chk(rd, 32'h30);
    finish_test();
  end
endmodule
